// ===== rtl/adcsq_pkg.sv
// constants and types for the converter sequencing control block
// Contract
// - start rise resets converter, sets busy; fall starts
// - busy flag bit 6, read-only
// - busy clears itself at conversion end
// - end of conversion sets interrupt request
// - channel select bits 2..0 route input
// - divider select 00/01/10 gives 2/8/32
// - pin enable bit: 0 digital, 1 analog
// - analog pin drops its pull-up
// - analog pin overrides port direction
// - unimplemented bits read as zero
// - conversion lasts sixteen converter clock periods
// - all pins digital powers converter down
// - result high byte, low nibble at 7..4
package adcsq_pkg;
	localparam logic [31:0] ADCSQ_OFF_CTRL   = 32'h0000_0000;
	localparam logic [31:0] ADCSQ_OFF_CLKSEL = 32'h0000_0004;
	localparam logic [31:0] ADCSQ_OFF_PINEN  = 32'h0000_0008;
	localparam logic [31:0] ADCSQ_OFF_RES_LO = 32'h0000_000C;
	localparam logic [31:0] ADCSQ_OFF_RES_HI = 32'h0000_0010;
	localparam logic [31:0] ADCSQ_OFF_IRQ    = 32'h0000_0014;
	localparam int ADCSQ_START_BIT = 7;
	localparam int ADCSQ_BUSY_BIT  = 6;
	localparam logic [2:0] ADCSQ_CHAN_RESET = 3'h0;
	localparam logic [1:0] ADCSQ_DIV_RESET  = 2'h0;
	localparam logic       ADCSQ_BUSY_RESET = 1'b1;
	localparam logic [1:0] ADCSQ_DIV2  = 2'h0;
	localparam logic [1:0] ADCSQ_DIV8  = 2'h1;
	localparam logic [1:0] ADCSQ_DIV32 = 2'h2;
	localparam logic [4:0] ADCSQ_HALF2  = 5'h00;
	localparam logic [4:0] ADCSQ_HALF8  = 5'h03;
	localparam logic [4:0] ADCSQ_HALF32 = 5'h0F;
	localparam logic [4:0] ADCSQ_CONV_PERIODS = 5'h10;
	localparam logic [1:0] ADCSQ_RESP_OKAY   = 2'h0;
	localparam logic [1:0] ADCSQ_RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		ADCSQ_IDLE  = 3'b001,
		ADCSQ_ARMED = 3'b010,
		ADCSQ_CONV  = 3'b100
	} adcsq_state_t;
endpackage

// ===== rtl/adcsq_clkdiv.sv
// converter clock divider with restart
`timescale 1ns/1ns
module adcsq_clkdiv
	import adcsq_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic       restart,
	input  wire logic       run,
	input  wire logic [1:0] div_sel,
	output logic            conv_clk,
	output logic            period_end
);
	logic [4:0] cnt_reg;
	logic [4:0] cnt_next;
	logic       clk_reg;
	logic       clk_next;
	logic       end_reg;
	logic       end_next;
	logic [4:0] half;

	// next divider values; each period is two half periods
	always_comb begin
		unique case (div_sel)
			ADCSQ_DIV2:  half = ADCSQ_HALF2;
			ADCSQ_DIV8:  half = ADCSQ_HALF8;
			ADCSQ_DIV32: half = ADCSQ_HALF32;
			default:     half = ADCSQ_HALF32; // undefined code
		endcase
		cnt_next = cnt_reg;
		clk_next = clk_reg;
		end_next = 1'b0;
		if (restart || !run) begin
			cnt_next = 5'h00;
			clk_next = 1'b0;
		end else if (cnt_reg >= half) begin
			cnt_next = 5'h00;
			clk_next = ~clk_reg;
			end_next = clk_reg; // falling half closes a period
		end else begin
			cnt_next = cnt_reg + 5'h01;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg <= 5'h00;
			clk_reg <= 1'b0;
			end_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			clk_reg <= clk_next;
			end_reg <= end_next;
		end
	end

	assign conv_clk   = clk_reg;
	assign period_end = end_reg;
endmodule

// ===== rtl/adcsq_top.sv
// converter sequencing control with axi4-lite registers
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module adcsq_top
	import adcsq_pkg::*;
#(
	parameter int PINS = 8
)(
	input  wire logic            clk_sys,
	input  wire logic            reset_n,
	input  wire logic [31:0]     s_axi_awaddr,
	input  wire logic            s_axi_awvalid,
	output logic                 s_axi_awready,
	input  wire logic [31:0]     s_axi_wdata,
	input  wire logic [3:0]      s_axi_wstrb,
	input  wire logic            s_axi_wvalid,
	output logic                 s_axi_wready,
	output logic [1:0]           s_axi_bresp,
	output logic                 s_axi_bvalid,
	input  wire logic            s_axi_bready,
	input  wire logic [31:0]     s_axi_araddr,
	input  wire logic            s_axi_arvalid,
	output logic                 s_axi_arready,
	output logic [31:0]          s_axi_rdata,
	output logic [1:0]           s_axi_rresp,
	output logic                 s_axi_rvalid,
	input  wire logic            s_axi_rready,
	input  wire logic [11:0]     conv_result,
	input  wire logic            conv_result_valid,
	input  wire logic            irq_enable,
	input  wire logic [PINS-1:0] port_dir_in,
	input  wire logic [PINS-1:0] port_pullup_en,
	output logic                 conv_reset,
	output logic                 conv_start,
	output logic                 conv_clk,
	output logic [2:0]           conv_channel,
	output logic                 conv_power_down,
	output logic [PINS-1:0]      pin_analog,
	output logic [PINS-1:0]      pin_dir_in,
	output logic [PINS-1:0]      pin_pullup,
	output logic                 irq_request,
	output logic                 irq_out
);
	// register state
	logic            start_reg, start_next;
	logic            busy_reg, busy_next;
	logic [2:0]      chan_reg, chan_next;
	logic [1:0]      div_reg, div_next;
	logic [PINS-1:0] pins_reg, pins_next;
	logic [11:0]     result_reg, result_next;
	logic            irqf_reg, irqf_next;
	logic            start_d_reg;
	adcsq_state_t    state_reg, state_next;
	logic [4:0]      per_reg, per_next;
	// bus state
	logic            awr_reg, awr_next;
	logic            wr_reg, wr_next;
	logic [31:0]     awaddr_reg, awaddr_next;
	logic [31:0]     wdata_reg, wdata_next;
	logic            wstrb0_reg, wstrb0_next;
	logic            bvalid_reg, bvalid_next;
	logic [1:0]      bresp_reg, bresp_next;
	logic            rvalid_reg, rvalid_next;
	logic [31:0]     rdata_reg, rdata_next;
	logic [1:0]      rresp_reg, rresp_next;
	// outputs registered
	logic            creset_reg, creset_next;
	logic            cstart_reg, cstart_next;
	logic [PINS-1:0] dir_reg, dir_next;
	logic [PINS-1:0] pu_reg, pu_next;
	logic            irqo_reg, irqo_next;
	logic            pd_reg, pd_next;
	logic            div_clk, period_end;
	logic            wr_fire, rise, fall;
	logic            conv_run;
	logic [31:0]     ctrl_rd;

	adcsq_clkdiv u_div (
		.clk_sys    (clk_sys),
		.reset_n    (reset_n),
		.restart    (rise),
		.run        (conv_run),
		.div_sel    (div_reg),
		.conv_clk   (div_clk),
		.period_end (period_end)
	);

	// edges of the stored start bit seen on system clock
	assign rise = start_reg & ~start_d_reg;
	assign fall = ~start_reg & start_d_reg;
	// divider stops on the last period, no seventeenth edge
	assign conv_run = (state_reg == ADCSQ_CONV)
		& ~(period_end & (per_reg == ADCSQ_CONV_PERIODS - 5'h01));
	assign wr_fire = awr_reg & wr_reg & ~bvalid_reg;
	assign ctrl_rd = {24'h0, start_reg, busy_reg, 3'h0, chan_reg};

	// register writes, sequencing and pin overrides
	always_comb begin
		start_next  = start_reg;
		chan_next   = chan_reg;
		div_next    = div_reg;
		pins_next   = pins_reg;
		busy_next   = busy_reg;
		result_next = result_reg;
		irqf_next   = irqf_reg;
		state_next  = state_reg;
		per_next    = per_reg;
		creset_next = 1'b0;
		cstart_next = 1'b0;
		if (wr_fire && wstrb0_reg) begin
			unique case (awaddr_reg)
				ADCSQ_OFF_CTRL: begin
					start_next = wdata_reg[ADCSQ_START_BIT];
					// channel code routes analog input n
					chan_next  = wdata_reg[2:0];
				end
				ADCSQ_OFF_CLKSEL: div_next  = wdata_reg[1:0];
				ADCSQ_OFF_PINEN:  pins_next = wdata_reg[PINS-1:0];
				ADCSQ_OFF_IRQ:    if (wdata_reg[0]) irqf_next = 1'b0;
				default: ;
			endcase
		end
		unique case (state_reg)
			ADCSQ_IDLE: begin
				// rising start resets converter and sets busy
				if (rise) begin
					busy_next   = 1'b1;
					creset_next = 1'b1;
					state_next  = ADCSQ_ARMED;
				end
			end
			ADCSQ_ARMED: begin
				// the falling start launches one conversion
				if (fall) begin
					state_next  = ADCSQ_CONV;
					cstart_next = 1'b1;
					per_next    = 5'h00;
				end
			end
			ADCSQ_CONV: begin
				// a new rise aborts and keeps busy high
				if (rise) begin
					creset_next = 1'b1;
					state_next  = ADCSQ_ARMED;
				end else if (period_end) begin
					if (per_reg == ADCSQ_CONV_PERIODS - 5'h01) begin
						busy_next   = 1'b0;
						result_next = conv_result_valid ? conv_result : result_reg;
						// request flag set, set wins over clear
						irqf_next   = 1'b1;
						state_next  = ADCSQ_IDLE;
					end else begin
						per_next = per_reg + 5'h01;
					end
				end
			end
			default: state_next = ADCSQ_IDLE;
		endcase
		irqo_next = irqf_next & irq_enable;
		// no analog pins powers converter down
		pd_next   = (pins_next == '0);
		pu_next   = port_pullup_en & ~pins_next;
		// enable bit selects analog or digital
		dir_next  = port_dir_in | pins_next;
	end

	// axi4-lite slave; read answers one cycle after handshake, write response two cycles after
	always_comb begin
		awr_next    = awr_reg;
		wr_next     = wr_reg;
		awaddr_next = awaddr_reg;
		wdata_next  = wdata_reg;
		wstrb0_next = wstrb0_reg;
		bvalid_next = bvalid_reg;
		bresp_next  = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		if (s_axi_awvalid && !awr_reg) begin
			awr_next    = 1'b1;
			awaddr_next = {s_axi_awaddr[31:2], 2'h0};
		end
		if (s_axi_wvalid && !wr_reg) begin
			wr_next     = 1'b1;
			wdata_next  = s_axi_wdata;
			wstrb0_next = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			bvalid_next = 1'b1;
			bresp_next  = (awaddr_reg <= ADCSQ_OFF_IRQ) ? ADCSQ_RESP_OKAY : ADCSQ_RESP_SLVERR;
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
			awr_next    = 1'b0;
			wr_next     = 1'b0;
		end
		if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_next = 1'b1;
			rresp_next  = ADCSQ_RESP_OKAY;
			unique case ({s_axi_araddr[31:2], 2'h0})
				ADCSQ_OFF_CTRL:   rdata_next = ctrl_rd;
				ADCSQ_OFF_CLKSEL: rdata_next = {30'h0, div_reg};
				ADCSQ_OFF_PINEN:  rdata_next = 32'({pins_reg});
				ADCSQ_OFF_RES_LO: rdata_next = {24'h0, result_reg[3:0], 4'h0};
				ADCSQ_OFF_RES_HI: rdata_next = {24'h0, result_reg[11:4]};
				ADCSQ_OFF_IRQ:    rdata_next = {31'h0, irqf_reg};
				default: begin
					rdata_next = 32'h0000_0000;
					rresp_next = ADCSQ_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			start_reg   <= 1'b0;
			start_d_reg <= 1'b0;
			busy_reg    <= ADCSQ_BUSY_RESET;
			chan_reg    <= ADCSQ_CHAN_RESET;
			div_reg     <= ADCSQ_DIV_RESET;
			pins_reg    <= '0;
			result_reg  <= 12'h000;
			irqf_reg    <= 1'b0;
			state_reg   <= ADCSQ_IDLE;
			per_reg     <= 5'h00;
			awr_reg     <= 1'b0;
			wr_reg      <= 1'b0;
			awaddr_reg  <= 32'h0000_0000;
			wdata_reg   <= 32'h0000_0000;
			wstrb0_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= 2'h0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= 2'h0;
			creset_reg  <= 1'b0;
			cstart_reg  <= 1'b0;
			dir_reg     <= '0;
			pu_reg      <= '0;
			irqo_reg    <= 1'b0;
			pd_reg      <= 1'b1;
		end else begin
			start_reg   <= start_next;
			start_d_reg <= start_reg;
			busy_reg    <= busy_next;
			chan_reg    <= chan_next;
			div_reg     <= div_next;
			pins_reg    <= pins_next;
			result_reg  <= result_next;
			irqf_reg    <= irqf_next;
			state_reg   <= state_next;
			per_reg     <= per_next;
			awr_reg     <= awr_next;
			wr_reg      <= wr_next;
			awaddr_reg  <= awaddr_next;
			wdata_reg   <= wdata_next;
			wstrb0_reg  <= wstrb0_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
			creset_reg  <= creset_next;
			cstart_reg  <= cstart_next;
			dir_reg     <= dir_next;
			pu_reg      <= pu_next;
			irqo_reg    <= irqo_next;
			pd_reg      <= pd_next;
		end
	end

	// outputs straight from flops except the ready signals, gated from valid (divider clock is its own flop)
	assign s_axi_awready   = s_axi_awvalid & ~awr_reg;
	assign s_axi_wready    = s_axi_wvalid & ~wr_reg;
	assign s_axi_bvalid    = bvalid_reg;
	assign s_axi_bresp     = bresp_reg;
	assign s_axi_arready   = s_axi_arvalid & ~rvalid_reg;
	assign s_axi_rvalid    = rvalid_reg;
	assign s_axi_rdata     = rdata_reg;
	assign s_axi_rresp     = rresp_reg;
	assign conv_reset      = creset_reg;
	assign conv_start      = cstart_reg;
	assign conv_clk        = div_clk;
	assign conv_channel    = chan_reg;
	assign conv_power_down = pd_reg;
	assign pin_analog      = pins_reg;
	assign pin_dir_in      = dir_reg;
	assign pin_pullup      = pu_reg;
	assign irq_request     = irqf_reg;
	assign irq_out         = irqo_reg;
endmodule

// ===== tb/adcsq_props.sv
// checker for the converter sequencing control block
`timescale 1ns/1ns
module adcsq_props
	import adcsq_pkg::*;
#(
	parameter int PINS = 8
)(
	input wire logic            clk_sys,
	input wire logic            reset_n,
	input wire logic            s_axi_awvalid,
	input wire logic            s_axi_wvalid,
	input wire logic            irq_enable,
	input wire logic [PINS-1:0] port_dir_in,
	input wire logic [PINS-1:0] port_pullup_en,
	input wire logic            conv_reset,
	input wire logic            conv_start,
	input wire logic            conv_clk,
	input wire logic            conv_power_down,
	input wire logic [PINS-1:0] pin_analog,
	input wire logic [PINS-1:0] pin_dir_in,
	input wire logic [PINS-1:0] pin_pullup,
	input wire logic            irq_request,
	input wire logic            irq_out
);
	logic [5:0] rise_reg;
	logic [5:0] rise_next;
	logic       cd_reg;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// converter clock rises since the last converter reset
	always_comb begin
		rise_next = rise_reg;
		if (conv_reset) rise_next = 6'h00;
		else if (conv_clk && !cd_reg && rise_reg != 6'h3F) rise_next = rise_reg + 6'h01;
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rise_reg <= 6'h00;
			cd_reg   <= 1'b0;
		end else begin
			rise_reg <= rise_next;
			cd_reg   <= conv_clk;
		end
	end
	a_sixteen_periods: assert property ($rose(irq_request) |-> rise_reg == 6'h10)
		else $error("conversion length wrong");
	a_reset_pulse: assert property (conv_reset |=> !conv_reset && !conv_start)
		else $error("converter reset pulse wrong");
	a_one_launch: assert property (conv_start |=> !conv_start)
		else $error("launch pulse too long");
	a_clk_idle: assert property ($rose(irq_request) |-> ##[0:2] !conv_clk)
		else $error("converter clock runs after end");
	a_irq_gate: assert property ($stable(irq_request) && $stable(irq_enable)
		|-> irq_out == (irq_request && irq_enable))
		else $error("interrupt gating wrong");
	// a clear lands two cycles after the later of address and data is taken
	a_irq_sticky: assert property (irq_request && !s_axi_awvalid && !s_axi_wvalid
		&& !$past(s_axi_awvalid) && !$past(s_axi_wvalid) |=> irq_request)
		else $error("request flag lost");
	a_pullup_drop: assert property ($past(reset_n) && $stable(pin_analog)
		&& $stable(port_pullup_en) |-> pin_pullup == (port_pullup_en & ~pin_analog))
		else $error("pull-up not dropped");
	a_dir_override: assert property ($past(reset_n) && $stable(pin_analog)
		&& $stable(port_dir_in) |-> pin_dir_in == (port_dir_in | pin_analog))
		else $error("direction not overridden");
	a_power_down: assert property ($past(reset_n) && $stable(pin_analog)
		|-> conv_power_down == (pin_analog == '0))
		else $error("power down wrong");
endmodule
bind adcsq_top adcsq_props #(.PINS(PINS)) u_props (.clk_sys, .reset_n, .s_axi_awvalid,
	.s_axi_wvalid, .irq_enable, .port_dir_in, .port_pullup_en, .conv_reset, .conv_start,
	.conv_clk, .conv_power_down, .pin_analog, .pin_dir_in, .pin_pullup, .irq_request, .irq_out);

// ===== tb/adcsq_core_model.sv
// behavioural converter core giving a result derived from the channel
`timescale 1ns/1ns
module adcsq_core_model
(
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic       conv_reset,
	input  wire logic       conv_start,
	input  wire logic [2:0] conv_channel,
	output logic [11:0]     conv_result,
	output logic            conv_result_valid
);
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			conv_result       <= 12'h000;
			conv_result_valid <= 1'b0;
		end else if (conv_reset) begin
			conv_result       <= ~conv_result;
			conv_result_valid <= 1'b0;
		end else if (conv_start) begin
			conv_result       <= {conv_channel, 9'h0A5};
			conv_result_valid <= 1'b1;
		end
	end
endmodule

// ===== tb/adcsq_tb.sv
// self-checking bench for the converter sequencing control block
`timescale 1ns/1ns
module tb;
	import adcsq_pkg::*;
	logic        clk_sys, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, conv_result_valid, irq_enable, conv_reset, conv_start;
	logic        conv_clk, conv_power_down, irq_request, irq_out, prev_clk;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, seed, r;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [11:0] conv_result;
	logic [2:0]  conv_channel, c;
	logic [7:0]  port_dir_in, port_pullup_en, pin_analog, pin_dir_in, pin_pullup, pe;
	logic [33:0] rq[$];
	logic [33:0] ex;
	logic [1:0]  bq[$];
	int          errors, checks_done, per, rises, div_exp, d, k;
	adcsq_top #(.PINS(8)) DUT (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_result, .conv_result_valid,
		.irq_enable, .port_dir_in, .port_pullup_en, .conv_reset, .conv_start, .conv_clk,
		.conv_channel, .conv_power_down, .pin_analog, .pin_dir_in, .pin_pullup, .irq_request,
		.irq_out);
	adcsq_core_model u_core (.clk_sys, .reset_n, .conv_reset, .conv_start, .conv_channel,
		.conv_result, .conv_result_valid);
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks_done %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic tmo();
		errors++;
		stop_test();
	endtask
	// write both channels, release each when taken, wait for response
	task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] e);
		int n;
		@(posedge clk_sys);
		bq.push_back(e);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 100) tmo();
	endtask
	// read with the expected word noted for the scoreboard
	task automatic rd(input logic [31:0] a, input logic [31:0] v, input logic [1:0] e);
		int n;
		@(posedge clk_sys);
		rq.push_back({e, v});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 100) tmo();
	endtask
	// scoreboard takes the oldest note at each response
	always @(posedge clk_sys) begin
		if (s_axi_rvalid && s_axi_rready) begin
			ex = rq.pop_front();
			check("rdata", s_axi_rdata, ex[31:0]);
			check("rresp", {30'h0, s_axi_rresp}, {30'h0, ex[33:32]});
		end
		if (s_axi_bvalid && s_axi_bready)
			check("bresp", {30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
	end
	// converter clock period and rise count per conversion
	always @(posedge clk_sys) begin
		per <= per + 1;
		prev_clk <= conv_clk;
		if (conv_clk && !prev_clk) begin
			if (rises > 0) check("period", per, div_exp);
			rises <= rises + 1;
			per <= 1;
		end
		if (conv_reset) rises <= 0;
	end
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		#3000000;
		tmo();
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		s_axi_wstrb = 4'hF;
		{irq_enable, port_dir_in, port_pullup_en, prev_clk} = 18'h00000;
		{errors, checks_done, per, rises, div_exp} = 0;
		seed = 32'h0001_149B;
		reset_n = 1'b0;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd(ADCSQ_OFF_CTRL, 32'h40, ADCSQ_RESP_OKAY);
		rd(ADCSQ_OFF_CLKSEL, 32'h00, ADCSQ_RESP_OKAY);
		wr(32'h18, 32'h01, ADCSQ_RESP_SLVERR);
		rd(32'h18, 32'h00, ADCSQ_RESP_SLVERR);
		for (k = 0; k < 5; k++) begin
			r = rnd();
			pe = (k == 0) ? 8'h00 : (k == 4) ? 8'hFF : r[7:0];
			port_dir_in <= r[15:8];
			port_pullup_en <= r[23:16];
			wr(ADCSQ_OFF_PINEN, {24'h0, pe}, ADCSQ_RESP_OKAY);
			rd(ADCSQ_OFF_PINEN, {24'h0, pe}, ADCSQ_RESP_OKAY);
			repeat (3) @(posedge clk_sys);
			check("analog", pin_analog, pe);
			check("pullup", pin_pullup, port_pullup_en & ~pe);
			check("dir", pin_dir_in, port_dir_in | pe);
			check("pdown", conv_power_down, pe == 8'h00);
		end
		wr(ADCSQ_OFF_CTRL, 32'hFF, ADCSQ_RESP_OKAY);
		rd(ADCSQ_OFF_CTRL, 32'hC7, ADCSQ_RESP_OKAY);
		wr(ADCSQ_OFF_CLKSEL, 32'hFF, ADCSQ_RESP_OKAY);
		rd(ADCSQ_OFF_CLKSEL, 32'h03, ADCSQ_RESP_OKAY);
		for (d = 0; d < 3; d++) begin
			r = rnd();
			c = r[2:0];
			irq_enable <= r[3];
			div_exp = 2 << (2 * d);
			wr(ADCSQ_OFF_CLKSEL, d, ADCSQ_RESP_OKAY);
			wr(ADCSQ_OFF_CTRL, {24'h0, 5'h10, c}, ADCSQ_RESP_OKAY);
			wr(ADCSQ_OFF_CTRL, {29'h0, c}, ADCSQ_RESP_OKAY);
			if (d == 2) begin
				wr(ADCSQ_OFF_CTRL, {24'h0, 5'h10, c}, ADCSQ_RESP_OKAY);
				rd(ADCSQ_OFF_CTRL, {24'h0, 5'h18, c}, ADCSQ_RESP_OKAY);
				wr(ADCSQ_OFF_CTRL, {29'h0, c}, ADCSQ_RESP_OKAY);
			end
			for (k = 0; k < 2000 && irq_request !== 1'b1; k++) @(posedge clk_sys);
			if (k == 2000) tmo();
			check("rises", rises, 16);
			check("channel", conv_channel, c);
			rd(ADCSQ_OFF_CTRL, {29'h0, c}, ADCSQ_RESP_OKAY);
			rd(ADCSQ_OFF_RES_LO, 32'h50, ADCSQ_RESP_OKAY);
			rd(ADCSQ_OFF_RES_HI, {24'h0, c, 5'h0A}, ADCSQ_RESP_OKAY);
			check("irq_out", irq_out, irq_enable);
			rd(ADCSQ_OFF_IRQ, 32'h01, ADCSQ_RESP_OKAY);
			wr(ADCSQ_OFF_IRQ, 32'h01, ADCSQ_RESP_OKAY);
			rd(ADCSQ_OFF_IRQ, 32'h00, ADCSQ_RESP_OKAY);
		end
		stop_test();
	end
endmodule
